// ### hdl/ivm_pkg.sv
package ivm_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned REGION_WORDS = 64;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned NGROUPS = 9;
  localparam int unsigned MAX_SRC = 14;
  localparam logic [15:0] REGION_BASE = 16'hff80;
  localparam logic [15:0] RESET_VEC = 16'hfffe;
  localparam logic [15:0] SLOT_TOP = 16'hfffd;
  localparam logic [15:0] BSL_PW_BASE = 16'hffe0;
  localparam logic [15:0] DBG_PW_BASE = 16'hff88;
  localparam logic [15:0] SIG_DBG_KEY_ADDR = 16'hff80;
  localparam logic [15:0] SIG_DBG_LEN_ADDR = 16'hff82;
  localparam logic [15:0] SIG_BSL_ADDR = 16'hff84;
  localparam logic [15:0] DBG_SIG_KEY = 16'haaaa;
  localparam logic [15:0] BSL_SIG_KEY = 16'h5555;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [IDX_W:0] BSL_PW_WORDS = 7'h10;
  localparam logic [IDX_W:0] DBG_PW_MAX_WORDS = 7'h3c;
  localparam logic [15:0] CODE_NONE = 16'h0000;

  typedef enum logic [3:0] {
    GRP_RESET, GRP_SYS_NMI, GRP_USER_NMI, GRP_COMP, GRP_TIMER_CC0,
    GRP_TIMER_IV, GRP_WDT_INTERVAL, GRP_SERIAL_A0, GRP_SERIAL_B0
  } group_e;

  typedef enum logic [1:0] {ST_SIGS, ST_BOOT, ST_RUN} boot_state_e;

  localparam logic [15:0] GROUP_VECTOR [NGROUPS] = '{16'hfffe, 16'hfffc, 16'hfffa,
    16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee};
  localparam int unsigned GROUP_WIDTH [NGROUPS] = '{8, 8, 3, 2, 1, 7, 1, 4, 14};
  localparam logic [NGROUPS-1:0] MASKABLE_GROUPS = 9'h1f8;
  localparam logic [NGROUPS-1:0] ACK_CLEARED_GROUPS = 9'h050;
  // serial flags still enabled in spi mode
  localparam logic [3:0] A0_SPI_FLAGS = 4'h3;
  localparam logic [13:0] B0_SPI_FLAGS = 14'h0c00;

  function automatic logic in_region(input logic [15:0] addr);
    return addr >= REGION_BASE;
  endfunction

  function automatic logic [IDX_W-1:0] word_index(input logic [15:0] addr);
    return addr[IDX_W:1];
  endfunction
endpackage

// ### hdl/flag_group.sv
`timescale 1ns/100ps
module flag_group #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned CODE_W = 5
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] src_en_i,
  input wire logic clear_top_i,
  output logic [CODE_W-1:0] code_o,
  output logic pending_o
);
  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] live;
  logic [WIDTH-1:0] top;

  assign live = flag_reg & src_en_i;
  assign pending_o = |live;

  // lowest index wins, so it is visited last
  always_comb begin
    top = '0;
    code_o = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (live[i]) begin
        top = '0;
        top[i] = 1'b1;
        code_o = CODE_W'(2 * (i + 1)); // R17
      end
    end
  end

  // a set arriving with the clear survives
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flag_reg <= '0;
    end else if (ce_i) begin
      flag_reg <= (flag_reg & ~(clear_top_i ? top : '0)) | set_i; // R17
    end
  end
endmodule

// ### hdl/interrupt_vector_map.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: words 0xff80 to 0xffff hold start address, vectors and signatures.
// R2: after reset the start address is taken from the word at 0xfffe.
// R3: vector slots descend from just below the reset word, one handler each.
// R4: with its signature set, slots 0xffe0 upward form the bootloader password.
// R5: signatures sit from 0xff80 up and are read before code runs.
// R6: the debug password starts at 0xff88 and grows upward.
// R7: the debug password may run on into the vector slots.
// R8: debug password length comes from the debug signature.
// R9: all reset causes use 0xfffe, highest priority, reported by cause register.
// R10: system nmi causes use 0xfffc, reported by the system nmi register.
// R11: user nmi causes use 0xfffa, reported by the user nmi register.
// R12: timer channels 1-6 and overflow share 0xfff4; channel 0 uses 0xfff6.
// R13: watchdog in interval mode requests through 0xfff2.
// R14: serial a0 uses 0xfff0; start and complete flags only in uart mode.
// R15: serial b0 uses 0xffee; only rx and tx flags in spi mode.
// R16: higher vector address wins; comparator flags share 0xfff8.
// R17: reading a vector register returns the top code and clears that flag.
module interrupt_vector_map (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] reset_cause_evt_i,
  input wire logic [7:0] system_nmi_evt_i,
  input wire logic [2:0] user_nmi_evt_i,
  input wire logic [1:0] comparator_evt_i,
  input wire logic capture_compare_flag0_evt_i,
  input wire logic [6:0] timer_b0_evt_i,
  input wire logic watchdog_flag_evt_i,
  input wire logic watchdog_interval_mode_i,
  input wire logic [3:0] serial_a0_evt_i,
  input wire logic serial_a0_uart_mode_i,
  input wire logic [13:0] serial_b0_evt_i,
  input wire logic serial_b0_i2c_mode_i,
  input wire logic gie_i,
  input wire logic [ivm_pkg::NGROUPS-1:0] group_enable_i,
  input wire logic int_ack_i,
  input wire logic vec_reg_rd_i,
  input wire ivm_pkg::group_e vec_reg_sel_i,
  input wire logic prog_we_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [15:0] prog_data_i,
  input wire logic fetch_rd_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic pw_rd_i,
  input wire logic pw_sel_debug_i,
  input wire logic [5:0] pw_index_i,
  output logic core_run_o,
  output logic [15:0] boot_pc_o,
  output logic boot_pc_valid_o,
  output logic irq_o,
  output logic [15:0] irq_vector_o,
  output logic [15:0] handler_addr_o,
  output logic ack_valid_o,
  output logic [15:0] vec_reg_data_o,
  output logic vec_reg_valid_o,
  output logic [15:0] fetch_data_o,
  output logic fetch_valid_o,
  output logic fetch_err_o,
  output logic bootloader_pw_en_o,
  output logic debug_pw_en_o,
  output logic [6:0] debug_pw_len_o,
  output logic [15:0] pw_word_o,
  output logic pw_ok_o
);
  import ivm_pkg::*;

  localparam logic [IDX_W-1:0] RESET_IDX = word_index(RESET_VEC);
  localparam logic [IDX_W-1:0] BSL_IDX = word_index(BSL_PW_BASE);
  localparam logic [IDX_W-1:0] DBG_IDX = word_index(DBG_PW_BASE);

  boot_state_e state_reg;
  logic [15:0] mem_reg [REGION_WORDS];
  logic [MAX_SRC-1:0] evt_bus [NGROUPS];
  logic [MAX_SRC-1:0] src_en_bus [NGROUPS];
  logic [CODE_W-1:0] code_arr [NGROUPS];
  logic [NGROUPS-1:0] pending_arr;
  logic [NGROUPS-1:0] eff_pending;
  logic [NGROUPS-1:0] clear_top;
  logic [3:0] win;
  logic take_ack;
  logic sig_done_reg;
  logic [CODE_W-1:0] sel_code;

  // pack events; the watchdog goes to reset or interval group by mode
  always_comb begin
    for (int g = 0; g < NGROUPS; g++) begin
      evt_bus[g] = '0;
      src_en_bus[g] = '1;
    end
    evt_bus[GRP_RESET][7:0] = reset_cause_evt_i; // R9
    evt_bus[GRP_RESET][2] = reset_cause_evt_i[2] | (watchdog_flag_evt_i & ~watchdog_interval_mode_i);
    evt_bus[GRP_SYS_NMI][7:0] = system_nmi_evt_i; // R10
    evt_bus[GRP_USER_NMI][2:0] = user_nmi_evt_i; // R11
    evt_bus[GRP_COMP][1:0] = comparator_evt_i; // R16
    evt_bus[GRP_TIMER_CC0][0] = capture_compare_flag0_evt_i; // R12
    evt_bus[GRP_TIMER_IV][6:0] = timer_b0_evt_i; // R12
    evt_bus[GRP_WDT_INTERVAL][0] = watchdog_flag_evt_i & watchdog_interval_mode_i; // R13
    evt_bus[GRP_SERIAL_A0][3:0] = serial_a0_evt_i; // R14
    src_en_bus[GRP_SERIAL_A0][3:0] = serial_a0_uart_mode_i ? 4'hf : A0_SPI_FLAGS; // R14
    evt_bus[GRP_SERIAL_B0] = serial_b0_evt_i; // R15
    src_en_bus[GRP_SERIAL_B0] = serial_b0_i2c_mode_i ? '1 : B0_SPI_FLAGS; // R15
  end

  generate
    for (genvar g = 0; g < NGROUPS; g++) begin : grp
      localparam int unsigned W = GROUP_WIDTH[g];
      flag_group #(.WIDTH(W), .CODE_W(CODE_W)) u_flags (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .set_i(evt_bus[g][W-1:0] & src_en_bus[g][W-1:0]),
        .src_en_i(src_en_bus[g][W-1:0]),
        .clear_top_i(clear_top[g]),
        .code_o(code_arr[g]),
        .pending_o(pending_arr[g])
      );
    end
  endgenerate

  // lowest group index has the highest vector address
  always_comb begin
    eff_pending = pending_arr & (~MASKABLE_GROUPS | (group_enable_i & {NGROUPS{gie_i}}));
    win = '0;
    for (int g = NGROUPS - 1; g >= 0; g--) begin
      if (eff_pending[g]) begin
        win = 4'(g); // R16
      end
    end
  end

  assign take_ack = int_ack_i && (state_reg == ST_RUN) && (|eff_pending);
  assign sel_code = code_arr[vec_reg_sel_i];

  always_comb begin
    for (int g = 0; g < NGROUPS; g++) begin
      clear_top[g] = (vec_reg_rd_i && (vec_reg_sel_i == group_e'(g))) // R17
        || (take_ack && (win == 4'(g)) && ACK_CLEARED_GROUPS[g]); // R12
    end
  end

  // vector region storage; writes outside it are dropped
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < REGION_WORDS; i++) begin
        mem_reg[i] <= ERASED_WORD;
      end
    end else if (ce_i && prog_we_i && in_region(prog_addr_i)) begin
      mem_reg[word_index(prog_addr_i)] <= prog_data_i; // R1
    end
  end

  // start-up: signatures first, then the reset word, then run
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_SIGS;
      sig_done_reg <= 1'b0;
      bootloader_pw_en_o <= 1'b0;
      debug_pw_en_o <= 1'b0;
      debug_pw_len_o <= '0;
      boot_pc_o <= '0;
      boot_pc_valid_o <= 1'b0;
    end else if (ce_i) begin
      unique case (state_reg)
        ST_SIGS: begin
          sig_done_reg <= 1'b1; // R5
          bootloader_pw_en_o <= mem_reg[word_index(SIG_BSL_ADDR)] == BSL_SIG_KEY; // R4
          debug_pw_en_o <= mem_reg[word_index(SIG_DBG_KEY_ADDR)] == DBG_SIG_KEY;
          // length is clamped so the password never leaves the region
          if (mem_reg[word_index(SIG_DBG_LEN_ADDR)] > 16'(DBG_PW_MAX_WORDS)) begin
            debug_pw_len_o <= DBG_PW_MAX_WORDS; // R8
          end else begin
            debug_pw_len_o <= mem_reg[word_index(SIG_DBG_LEN_ADDR)][6:0]; // R8
          end
          state_reg <= ST_BOOT;
        end
        ST_BOOT: begin
          boot_pc_o <= mem_reg[RESET_IDX]; // R2
          boot_pc_valid_o <= 1'b1;
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          boot_pc_valid_o <= 1'b0;
        end
      endcase
    end
  end

  assign core_run_o = (state_reg == ST_RUN);

  // request and acknowledge towards the cpu
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      irq_vector_o <= RESET_VEC;
      handler_addr_o <= '0;
      ack_valid_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= (state_reg == ST_RUN) && (|eff_pending);
      irq_vector_o <= GROUP_VECTOR[win]; // R3
      ack_valid_o <= take_ack;
      if (take_ack) begin
        handler_addr_o <= mem_reg[word_index(GROUP_VECTOR[win])]; // R3
      end
    end
  end

  // vector register reads return the top code of the chosen group
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      vec_reg_data_o <= CODE_NONE;
      vec_reg_valid_o <= 1'b0;
    end else if (ce_i) begin
      vec_reg_valid_o <= vec_reg_rd_i;
      if (vec_reg_rd_i) begin
        vec_reg_data_o <= 16'(sel_code); // R17
      end
    end
  end

  // word fetch and password words
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fetch_data_o <= '0;
      fetch_valid_o <= 1'b0;
      fetch_err_o <= 1'b0;
      pw_word_o <= '0;
      pw_ok_o <= 1'b0;
    end else if (ce_i) begin
      fetch_valid_o <= fetch_rd_i;
      fetch_err_o <= fetch_rd_i && !in_region(fetch_addr_i);
      if (fetch_rd_i) begin
        fetch_data_o <= in_region(fetch_addr_i) ? mem_reg[word_index(fetch_addr_i)] : '0;
      end
      if (pw_rd_i && pw_sel_debug_i) begin
        // indices past the signatures walk straight into the vector slots
        pw_word_o <= mem_reg[DBG_IDX + pw_index_i]; // R6 R7
        pw_ok_o <= debug_pw_en_o && ({1'b0, pw_index_i} < debug_pw_len_o); // R8
      end else if (pw_rd_i) begin
        pw_word_o <= mem_reg[BSL_IDX + pw_index_i]; // R4
        pw_ok_o <= bootloader_pw_en_o && ({1'b0, pw_index_i} < BSL_PW_WORDS); // R4
      end
    end
  end

  property p_boot_pc;
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_BOOT && ce_i) |=> boot_pc_valid_o && boot_pc_o == $past(mem_reg[RESET_IDX]);
  endproperty
  a_boot_pc: assert property (p_boot_pc) else $error("boot pc not from reset word"); // R2

  property p_no_run_before_sigs;
    @(posedge core_clk_i) disable iff (reset_i)
    !sig_done_reg |-> !core_run_o && !irq_o;
  endproperty
  a_no_run_before_sigs: assert property (p_no_run_before_sigs) else $error("ran early"); // R5

  property p_reset_first;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && core_run_o && eff_pending[GRP_RESET]) |=> irq_o && irq_vector_o == RESET_VEC;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset group not first"); // R9

  property p_sys_nmi;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && core_run_o && eff_pending[GRP_SYS_NMI] && !eff_pending[GRP_RESET])
      |=> irq_vector_o == 16'hfffc;
  endproperty
  a_sys_nmi: assert property (p_sys_nmi) else $error("system nmi vector wrong"); // R10

  property p_user_nmi;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && core_run_o && eff_pending[2:0] == 3'b100) |=> irq_vector_o == 16'hfffa;
  endproperty
  a_user_nmi: assert property (p_user_nmi) else $error("user nmi vector wrong"); // R11

  property p_vec_reg_read;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && vec_reg_rd_i) |=> vec_reg_valid_o && vec_reg_data_o == 16'($past(sel_code));
  endproperty
  a_vec_reg_read: assert property (p_vec_reg_read) else $error("vector code wrong"); // R17

  property p_bsl_pw;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && pw_rd_i && !pw_sel_debug_i && bootloader_pw_en_o && pw_index_i < 6'h10)
      |=> pw_ok_o && pw_word_o == $past(mem_reg[BSL_IDX + pw_index_i]);
  endproperty
  a_bsl_pw: assert property (p_bsl_pw) else $error("bootloader password word wrong"); // R4

  property p_dbg_pw_len;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && pw_rd_i && pw_sel_debug_i && {1'b0, pw_index_i} >= debug_pw_len_o) |=> !pw_ok_o;
  endproperty
  a_dbg_pw_len: assert property (p_dbg_pw_len) else $error("debug password overran"); // R8

  property p_dbg_pw_first;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && pw_rd_i && pw_sel_debug_i && pw_index_i == 6'h00)
      |=> pw_word_o == $past(mem_reg[DBG_IDX]);
  endproperty
  a_dbg_pw_first: assert property (p_dbg_pw_first) else $error("debug password base wrong"); // R6

  property p_cc0_ack_clear;
    @(posedge core_clk_i) disable iff (reset_i)
    (ce_i && take_ack && win == 4'(GRP_TIMER_CC0) && !capture_compare_flag0_evt_i)
      |=> !pending_arr[GRP_TIMER_CC0];
  endproperty
  a_cc0_ack_clear: assert property (p_cc0_ack_clear) else $error("cc0 flag kept"); // R12

  c_ack: cover property (@(posedge core_clk_i) disable iff (reset_i) take_ack && ce_i);
  c_b0_read: cover property (@(posedge core_clk_i) disable iff (reset_i)
    vec_reg_rd_i && vec_reg_sel_i == GRP_SERIAL_B0 && sel_code != '0);
  c_debug_pw: cover property (@(posedge core_clk_i) disable iff (reset_i)
    pw_ok_o && debug_pw_en_o);
endmodule

// ### tb/cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model (
  input wire logic core_clk_i,
  input wire logic boot_pc_valid_i,
  input wire logic [15:0] boot_pc_i,
  input wire logic ack_valid_i,
  input wire logic [15:0] handler_addr_i,
  input wire logic vec_reg_valid_i,
  input wire logic [15:0] vec_reg_data_i,
  input wire logic fetch_valid_i,
  input wire logic [15:0] fetch_data_i,
  output logic int_ack_o,
  output logic vec_reg_rd_o,
  output ivm_pkg::group_e vec_reg_sel_o,
  output logic fetch_rd_o,
  output logic [15:0] fetch_addr_o,
  output logic [15:0] pc_o
);
  import ivm_pkg::*;
  initial begin
    int_ack_o = 1'b0;
    vec_reg_rd_o = 1'b0;
    vec_reg_sel_o = GRP_RESET;
    fetch_rd_o = 1'b0;
    fetch_addr_o = 16'h0000;
    pc_o = 16'h0000;
  end
  // start address is taken on the boot pulse only
  always @(posedge core_clk_i) begin
    if (boot_pc_valid_i === 1'b1) begin
      pc_o <= boot_pc_i;
    end
  end
  // kind 0 ack, 1 vector register read, 2 fetch; slow adds idle cycles first
  task automatic request(input int kind, input logic [15:0] arg, input int slow,
                         output logic [15:0] data, output logic ok);
    int n;
    repeat (slow + 1) @(posedge core_clk_i);
    #1;
    if (kind == 0) int_ack_o = 1'b1;
    if (kind == 1) vec_reg_rd_o = 1'b1;
    if (kind == 1) vec_reg_sel_o = group_e'(arg[3:0]);
    if (kind == 2) fetch_rd_o = 1'b1;
    if (kind == 2) fetch_addr_o = arg;
    @(posedge core_clk_i);
    #1;
    int_ack_o = 1'b0;
    vec_reg_rd_o = 1'b0;
    fetch_rd_o = 1'b0;
    // released selects show garbage so a stale value cannot pass
    vec_reg_sel_o = group_e'(~arg[3:0]);
    fetch_addr_o = ~arg;
    ok = 1'b0;
    data = 16'h0000;
    for (n = 0; n < 4; n++) begin
      if ((kind == 0 ? ack_valid_i : kind == 1 ? vec_reg_valid_i : fetch_valid_i) === 1'b1) begin
        data = kind == 0 ? handler_addr_i : kind == 1 ? vec_reg_data_i : fetch_data_i;
        ok = 1'b1;
        break;
      end
      @(posedge core_clk_i);
      #1;
    end
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  import ivm_pkg::*;
  logic core_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
  logic [7:0] reset_cause_evt_i = '0, system_nmi_evt_i = '0;
  logic [2:0] user_nmi_evt_i = '0;
  logic [1:0] comparator_evt_i = '0;
  logic [6:0] timer_b0_evt_i = '0;
  logic [3:0] serial_a0_evt_i = '0;
  logic [13:0] serial_b0_evt_i = '0;
  logic capture_compare_flag0_evt_i = 0, watchdog_flag_evt_i = 0, watchdog_interval_mode_i = 1;
  logic serial_a0_uart_mode_i = 1, serial_b0_i2c_mode_i = 1, gie_i = 1;
  logic [8:0] group_enable_i = 9'h1ff;
  logic prog_we_i = 0, pw_rd_i = 0, pw_sel_debug_i = 0;
  logic [15:0] prog_addr_i = '0, prog_data_i = '0;
  logic [5:0] pw_index_i = '0;
  logic int_ack_i, vec_reg_rd_i, fetch_rd_i;
  group_e vec_reg_sel_i;
  logic [15:0] fetch_addr_i, pc;
  logic core_run_o, boot_pc_valid_o, irq_o, ack_valid_o, vec_reg_valid_o, fetch_valid_o;
  logic fetch_err_o, bootloader_pw_en_o, debug_pw_en_o, pw_ok_o;
  logic [15:0] boot_pc_o, irq_vector_o, handler_addr_o, vec_reg_data_o, fetch_data_o, pw_word_o;
  logic [6:0] debug_pw_len_o;
  int n_mismatch = 0, samples_checked = 0;
  logic [15:0] d;
  logic ok;

  always #20 core_clk_i = ~core_clk_i;

  interrupt_vector_map i_dut (.core_clk_i, .reset_i, .ce_i, .reset_cause_evt_i, .system_nmi_evt_i,
    .user_nmi_evt_i, .comparator_evt_i, .capture_compare_flag0_evt_i, .timer_b0_evt_i,
    .watchdog_flag_evt_i, .watchdog_interval_mode_i, .serial_a0_evt_i, .serial_a0_uart_mode_i,
    .serial_b0_evt_i, .serial_b0_i2c_mode_i, .gie_i, .group_enable_i, .int_ack_i, .vec_reg_rd_i,
    .vec_reg_sel_i, .prog_we_i, .prog_addr_i, .prog_data_i, .fetch_rd_i, .fetch_addr_i, .pw_rd_i,
    .pw_sel_debug_i, .pw_index_i, .core_run_o, .boot_pc_o, .boot_pc_valid_o, .irq_o,
    .irq_vector_o, .handler_addr_o, .ack_valid_o, .vec_reg_data_o, .vec_reg_valid_o,
    .fetch_data_o, .fetch_valid_o, .fetch_err_o, .bootloader_pw_en_o, .debug_pw_en_o,
    .debug_pw_len_o, .pw_word_o, .pw_ok_o);

  cpu_core_model i_cpu (.core_clk_i, .boot_pc_valid_i(boot_pc_valid_o), .boot_pc_i(boot_pc_o),
    .ack_valid_i(ack_valid_o), .handler_addr_i(handler_addr_o), .vec_reg_valid_i(vec_reg_valid_o),
    .vec_reg_data_i(vec_reg_data_o), .fetch_valid_i(fetch_valid_o), .fetch_data_i(fetch_data_o),
    .int_ack_o(int_ack_i), .vec_reg_rd_o(vec_reg_rd_i), .vec_reg_sel_o(vec_reg_sel_i),
    .fetch_rd_o(fetch_rd_i), .fetch_addr_o(fetch_addr_i), .pc_o(pc));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic prog(input logic [15:0] a, input logic [15:0] v);
    step(1);
    prog_we_i = 1'b1;
    prog_addr_i = a;
    prog_data_i = v;
    step(1);
    prog_we_i = 1'b0;
  endtask

  // one-cycle event pulse on every group in gm, same bit pattern each
  task automatic pulse(input logic [8:0] gm, input logic [13:0] bits);
    step(1);
    if (gm[0]) reset_cause_evt_i = bits[7:0];
    if (gm[1]) system_nmi_evt_i = bits[7:0];
    if (gm[2]) user_nmi_evt_i = bits[2:0];
    if (gm[3]) comparator_evt_i = bits[1:0];
    if (gm[4]) capture_compare_flag0_evt_i = bits[0];
    if (gm[5]) timer_b0_evt_i = bits[6:0];
    if (gm[6]) watchdog_flag_evt_i = bits[0];
    if (gm[7]) serial_a0_evt_i = bits[3:0];
    if (gm[8]) serial_b0_evt_i = bits;
    step(1);
    {reset_cause_evt_i, system_nmi_evt_i, user_nmi_evt_i, comparator_evt_i,
     capture_compare_flag0_evt_i, timer_b0_evt_i, watchdog_flag_evt_i, serial_a0_evt_i,
     serial_b0_evt_i} = '0;
    step(1);
  endtask

  task automatic vread(input int g, input logic [15:0] exp);
    i_cpu.request(1, 16'(g), 0, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check(d, exp);
  endtask

  task automatic t_boot();
    for (int n = 0; n < 10 && core_run_o !== 1'b1; n++) step(1);
    check({15'h0000, core_run_o}, 16'h0001);
    // the start address pulse stands one cycle; the cpu only takes it on the next edge
    check({15'h0000, boot_pc_valid_o}, 16'h0001);
    check(boot_pc_o, ERASED_WORD);
    step(1);
    check({15'h0000, boot_pc_valid_o}, 16'h0000);
    check(pc, ERASED_WORD);
    check({14'h0000, bootloader_pw_en_o, debug_pw_en_o}, 16'h0000);
    check({9'h000, debug_pw_len_o}, 16'(DBG_PW_MAX_WORDS));
    for (int g = 0; g < 9; g++) prog(16'hfffe - 16'(2 * g), 16'h4000 + 16'(g));
    prog(16'hffe0, 16'h1234);
    prog(16'hff88, 16'h5678);
    i_cpu.request(2, 16'hfffe, 0, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check(d, 16'h4000);
    i_cpu.request(2, 16'hff7e, 1, d, ok);
    check({15'h0000, fetch_err_o}, 16'h0001);
    check(d, 16'h0000);
  endtask

  task automatic t_groups();
    for (int g = 0; g < 9; g++) begin
      pulse(9'h001 << g, 14'h0001);
      check({15'h0000, irq_o}, 16'h0001);
      check(irq_vector_o, 16'hfffe - 16'(2 * g));
      i_cpu.request(0, 16'h0000, g % 3, d, ok);
      check({15'h0000, ok}, 16'h0001);
      check(d, 16'h4000 + 16'(g));
      // ack alone clears the single-source groups
      if (g != 4 && g != 6) vread(g, 16'h0002);
      step(3);
      check({15'h0000, irq_o}, 16'h0000);
    end
  endtask

  task automatic t_prio();
    pulse(9'h0a8, 14'h0001);
    check(irq_vector_o, 16'hfff8);
    gie_i = 1'b0;
    step(3);
    check({15'h0000, irq_o}, 16'h0000);
    gie_i = 1'b1;
    group_enable_i[5] = 1'b0;
    vread(3, 16'h0002);
    step(3);
    check(irq_vector_o, 16'hfff0);
    group_enable_i[5] = 1'b1;
    vread(5, 16'h0002);
    vread(7, 16'h0002);
  endtask

  task automatic t_modes();
    serial_a0_uart_mode_i = 1'b0;
    pulse(9'h080, 14'h0004);
    vread(7, 16'h0000);
    serial_a0_uart_mode_i = 1'b1;
    pulse(9'h080, 14'h0004);
    vread(7, 16'h0006);
    serial_b0_i2c_mode_i = 1'b0;
    pulse(9'h100, 14'h0401);
    vread(8, 16'h0016);
    vread(8, 16'h0000);
    watchdog_interval_mode_i = 1'b0;
    pulse(9'h040, 14'h0001);
    vread(0, 16'h0006);
    pulse(9'h020, 14'h000a);
    vread(5, 16'h0004);
    vread(5, 16'h0008);
    vread(5, 16'h0000);
  endtask

  // with the clock enable low nothing is taken or answered
  task automatic t_freeze();
    pulse(9'h010, 14'h0001);
    ce_i = 1'b0;
    i_cpu.request(0, 16'h0000, 0, d, ok);
    check({15'h0000, ok}, 16'h0000);
    check({15'h0000, irq_o}, 16'h0001);
    pulse(9'h001, 14'h0001);
    ce_i = 1'b1;
    step(3);
    check(irq_vector_o, 16'hfff6);
    i_cpu.request(0, 16'h0000, 0, d, ok);
    check(d, 16'h4004);
    step(3);
    check({15'h0000, irq_o}, 16'h0000);
  endtask

  task automatic pw(input logic dbg, input logic [5:0] idx, input logic [15:0] exp);
    step(1);
    pw_rd_i = 1'b1;
    pw_sel_debug_i = dbg;
    pw_index_i = idx;
    step(1);
    pw_rd_i = 1'b0;
    check(pw_word_o, exp);
    check({15'h0000, pw_ok_o}, 16'h0000);
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    t_boot();
    t_groups();
    t_prio();
    t_modes();
    t_freeze();
    pw(1'b0, 6'h00, 16'h1234);
    pw(1'b1, 6'h00, 16'h5678);
    pw(1'b1, 6'h3b, 16'h4000);
    pw(1'b1, 6'h3c, ERASED_WORD);
    results();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    results();
  end
endmodule
